/* inc/mim_pkg.sv */
// constants and types for the masked interrupt flag logic of the memory interface
// assumes a single 40 MHz core clock and a plain strobe register port
package mim_pkg;

    // register port geometry
    localparam int MIM_ADDR_W = 8;
    localparam int MIM_DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] MIM_OFS_RAW_FLAGS = 8'h00;
    localparam logic [7:0] MIM_OFS_MASKED_FLAGS = 8'h04;
    localparam logic [7:0] MIM_OFS_ENABLE_SET = 8'h08;
    localparam logic [7:0] MIM_OFS_ENABLE_CLEAR = 8'h0C;
    localparam logic [7:0] MIM_OFS_WAIT_CFG = 8'h10;

    // flag and enable field positions, shared by all four flag registers
    localparam int MIM_BIT_TIMEOUT = 0;
    localparam int MIM_BIT_LINE_TRAP = 1;
    localparam int MIM_BIT_WAIT_RISE = 2;
    localparam int MIM_FLAG_W = 3;

    // wait cycle configuration field
    localparam int MIM_LIMIT_LSB = 0;
    localparam int MIM_LIMIT_W = 8;

    // reset values
    localparam logic [2:0] MIM_FLAGS_RST = 3'h0;
    localparam logic [7:0] MIM_LIMIT_RST = 8'hFF;
    localparam logic [31:0] MIM_RDATA_RST = 32'h0000_0000;

    // clock: 40 MHz, period in ns
    localparam int MIM_CLK_PERIOD_NS = 25;

    // order matches the field positions above
    typedef struct packed {
        logic wait_rise;
        logic line_trap;
        logic timeout;
    } mim_flags_t;

    // wait timeout watcher states, one-hot
    typedef enum logic [2:0] {
        MIM_TO_IDLE = 3'b001,
        MIM_TO_COUNT = 3'b010,
        MIM_TO_DONE = 3'b100
    } mim_to_state_t;

endpackage

/* verilog/mim_pin_sync.sv */
// three-stage synchroniser and rising-edge detector for the external wait pin
// assumes the pin is asynchronous to core_clk_i
`timescale 1ns/1ps
module mim_pin_sync (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o
);

    logic [2:0] stage;
    logic level;
    logic rise;
    logic [2:0] next_stage;
    logic next_level;
    logic next_rise;

    always_comb begin
        next_stage = {stage[1:0], pin_i};
        next_level = level;
        next_rise = 1'b0;
        // stage[0] feeds only stage[1]; a change is accepted once stages 1 and 2 agree
        if (stage[1] == stage[2]) begin
            next_level = stage[2];
            next_rise = stage[2] & ~level;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage <= 3'h0;
            level <= 1'b0;
            rise <= 1'b0;
        end else begin
            stage <= next_stage;
            level <= next_level;
            rise <= next_rise;
        end
    end

    assign level_o = level;
    assign rise_o = rise;

endmodule // mim_pin_sync

/* verilog/mim_irq_masking.sv */
// raw and masked interrupt flags, enables and wait timeout watcher of the memory interface
// assumes the async controller raises ext_access_active_i (same clock) during extended accesses,
// line trap events arrive as one-cycle pulses on the same clock, and the wait pin is asynchronous
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps

// What this block does
// - a pulse goes to the cpu interrupt controller when masked timeout sets
// - a masked flag sets only while its enable is on
// - bits 31..3 of the masked flag register read zero; software writes zeros
// - masked wait rise flag sets on a wait pin rising edge if enabled
// - writing one to masked wait rise clears it and the raw wait rise flag
// - masked line trap flag sets on a line trap event if enabled
// - writing one to masked line trap clears it and the raw line trap flag
// - masked timeout sets when wait stays active past the limit, if enabled
// - writing one to masked timeout clears it and the raw timeout flag
// - writing zero to a masked flag changes neither it nor its raw flag
// - with timeout enable on, a timeout sets masked timeout and interrupts
// - with timeout enable off, masked timeout reads zero and no interrupt occurs
// - writing one to the timeout enable set bit turns the timeout interrupt on
// - without the wait pin, flag and enable registers read zero and ignore writes
// - the raw timeout flag sets on every timeout regardless of enables
// - enable set bits set both views; only a clear-register one clears them
module mim_irq_masking import mim_pkg::*; #(
    parameter bit WAIT_PIN_PRESENT = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [MIM_ADDR_W-1:0] reg_addr_i,
    input wire logic [MIM_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [MIM_DATA_W-1:0] reg_rdata_o,
    input wire logic external_wait_pin_i,
    input wire logic ext_access_active_i,
    input wire logic line_trap_event_i,
    output logic irq_o,
    output logic timeout_event_o
);

    // low three bits of a write to the given offset, zero on any other cycle
    function automatic mim_flags_t write_ones(
        input logic wr,
        input logic [MIM_ADDR_W-1:0] addr,
        input logic [MIM_DATA_W-1:0] wdata,
        input logic [MIM_ADDR_W-1:0] ofs
    );
        mim_flags_t bits;
        bits = mim_flags_t'(MIM_FLAGS_RST);
        if (wr && (addr == ofs)) begin
            bits = mim_flags_t'(wdata[MIM_FLAG_W-1:0]);
        end
        return bits;
    endfunction

    // a flag register word with the reserved bits held at zero
    function automatic logic [MIM_DATA_W-1:0] flag_word(input mim_flags_t f);
        return {{(MIM_DATA_W-MIM_FLAG_W){1'b0}}, f};
    endfunction

    // an extended access stalled by an active wait pin
    function automatic logic wait_stalled(
        input logic active,
        input logic level
    );
        return active & level;
    endfunction

    // set wins over clear when an event and a write of one meet in one cycle
    function automatic mim_flags_t flag_next(
        input mim_flags_t cur,
        input mim_flags_t clr,
        input mim_flags_t ev
    );
        return mim_flags_t'((cur & ~clr) | ev);
    endfunction

    localparam logic PRESENT = WAIT_PIN_PRESENT;

    // wait pin after synchronisation
    logic wait_level;
    logic wait_rise;

    mim_pin_sync u_wait_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(external_wait_pin_i),
        .level_o(wait_level),
        .rise_o(wait_rise)
    );

    // state
    mim_flags_t raw_irq_flags_reg;
    mim_flags_t masked_irq_flags_reg;
    mim_flags_t irq_enable;
    logic [MIM_LIMIT_W-1:0] wait_timeout_limit;
    mim_to_state_t to_state;
    logic [MIM_LIMIT_W-1:0] to_cnt;
    logic timeout_pulse;
    logic irq_pulse;
    logic [MIM_DATA_W-1:0] rdata;

    // next values
    mim_flags_t next_raw;
    mim_flags_t next_masked;
    mim_flags_t next_enable;
    logic [MIM_LIMIT_W-1:0] next_limit;
    mim_to_state_t next_to_state;
    logic [MIM_LIMIT_W-1:0] next_to_cnt;
    logic next_timeout_pulse;
    logic next_irq_pulse;
    logic [MIM_DATA_W-1:0] next_rdata;

    // decoded software actions and hardware events
    mim_flags_t clr_raw_wr;
    mim_flags_t clr_masked_wr;
    mim_flags_t flag_clear;
    mim_flags_t enable_set;
    mim_flags_t enable_clear;
    mim_flags_t hw_event;
    logic timeout_hit;

    // wait timeout watcher: counts cycles of active wait inside an extended access
    always_comb begin
        next_to_state = to_state;
        next_to_cnt = to_cnt;
        timeout_hit = 1'b0;
        case (to_state)
            MIM_TO_IDLE: begin
                next_to_cnt = '0;
                if (wait_stalled(ext_access_active_i, wait_level)) begin
                    next_to_state = MIM_TO_COUNT;
                end
            end
            MIM_TO_COUNT: begin
                if (!wait_stalled(ext_access_active_i, wait_level)) begin
                    next_to_state = MIM_TO_IDLE;
                    next_to_cnt = '0;
                end else if (to_cnt == wait_timeout_limit) begin
                    // still waiting after the programmed number of cycles
                    timeout_hit = 1'b1;
                    next_to_state = MIM_TO_DONE;
                end else begin
                    next_to_cnt = to_cnt + MIM_LIMIT_W'(1);
                end
            end
            MIM_TO_DONE: begin
                // one timeout per stuck access; rearm once the access or the wait ends
                if (!wait_stalled(ext_access_active_i, wait_level)) begin
                    next_to_state = MIM_TO_IDLE;
                    next_to_cnt = '0;
                end
            end
            default: begin
                next_to_state = MIM_TO_IDLE;
                next_to_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            to_state <= MIM_TO_IDLE;
            to_cnt <= '0;
        end else begin
            to_state <= next_to_state;
            to_cnt <= next_to_cnt;
        end
    end

    // decoded register writes and hardware events
    always_comb begin
        // a one written to either flag view clears both views
        clr_raw_wr = write_ones(reg_wr_i, reg_addr_i, reg_wdata_i, MIM_OFS_RAW_FLAGS);
        clr_masked_wr = write_ones(reg_wr_i, reg_addr_i, reg_wdata_i, MIM_OFS_MASKED_FLAGS);
        flag_clear = mim_flags_t'(clr_raw_wr | clr_masked_wr);
        enable_set = write_ones(reg_wr_i, reg_addr_i, reg_wdata_i, MIM_OFS_ENABLE_SET);
        enable_clear = write_ones(reg_wr_i, reg_addr_i, reg_wdata_i, MIM_OFS_ENABLE_CLEAR);
        hw_event.timeout = timeout_hit;
        hw_event.line_trap = line_trap_event_i;
        hw_event.wait_rise = wait_rise;
    end

    // enables: set by a one to the set register, cleared only by a one to the clear register
    always_comb begin
        next_enable = mim_flags_t'((irq_enable & ~enable_clear) | enable_set);
        if (!PRESENT) begin
            next_enable = mim_flags_t'(MIM_FLAGS_RST);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_enable <= mim_flags_t'(MIM_FLAGS_RST);
        end else begin
            irq_enable <= next_enable;
        end
    end

    // raw flags take every event regardless of enables
    // zeros in the written word leave flags alone since only ones reach flag_clear
    always_comb begin
        next_raw = flag_next(raw_irq_flags_reg, flag_clear, hw_event);
        if (!PRESENT) begin
            next_raw = mim_flags_t'(MIM_FLAGS_RST);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            raw_irq_flags_reg <= mim_flags_t'(MIM_FLAGS_RST);
        end else begin
            raw_irq_flags_reg <= next_raw;
        end
    end

    // masked flags follow events only while enabled; the enable both before and after this cycle's write must be on
    always_comb begin
        next_masked = mim_flags_t'(flag_next(masked_irq_flags_reg, flag_clear, hw_event) & next_enable);
        next_masked.wait_rise = irq_enable.wait_rise & next_masked.wait_rise;
        next_masked.line_trap = irq_enable.line_trap & next_masked.line_trap;
        next_masked.timeout = irq_enable.timeout & next_masked.timeout;
        if (!PRESENT) begin
            next_masked = mim_flags_t'(MIM_FLAGS_RST);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            masked_irq_flags_reg <= mim_flags_t'(MIM_FLAGS_RST);
        end else begin
            masked_irq_flags_reg <= next_masked;
        end
    end

    // timeout limit in core clock cycles; kept even on variants without the wait pin
    always_comb begin
        next_limit = wait_timeout_limit;
        if (reg_wr_i && (reg_addr_i == MIM_OFS_WAIT_CFG)) begin
            next_limit = reg_wdata_i[MIM_LIMIT_LSB +: MIM_LIMIT_W];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_timeout_limit <= MIM_LIMIT_RST;
        end else begin
            wait_timeout_limit <= next_limit;
        end
    end

    // one-cycle interrupt on the masked timeout flag going from 0 to 1
    always_comb begin
        next_irq_pulse = next_masked.timeout & ~masked_irq_flags_reg.timeout;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_pulse <= 1'b0;
        end else begin
            irq_pulse <= next_irq_pulse;
        end
    end

    // registered so the event lines up with the raw timeout flag
    always_comb begin
        next_timeout_pulse = timeout_hit;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timeout_pulse <= 1'b0;
        end else begin
            timeout_pulse <= next_timeout_pulse;
        end
    end

    // read port: data stand only in the cycle after the read strobe
    always_comb begin
        next_rdata = MIM_RDATA_RST;
        if (reg_rd_i) begin
            if (reg_addr_i == MIM_OFS_RAW_FLAGS) begin
                next_rdata = flag_word(raw_irq_flags_reg);
            end else if (reg_addr_i == MIM_OFS_MASKED_FLAGS) begin
                next_rdata = flag_word(masked_irq_flags_reg);
            end else if (reg_addr_i == MIM_OFS_ENABLE_SET) begin
                next_rdata = flag_word(irq_enable);
            end else if (reg_addr_i == MIM_OFS_ENABLE_CLEAR) begin
                next_rdata = flag_word(irq_enable);
            end else if (reg_addr_i == MIM_OFS_WAIT_CFG) begin
                next_rdata = {{(MIM_DATA_W-MIM_LIMIT_W){1'b0}}, wait_timeout_limit};
            end else begin
                next_rdata = MIM_RDATA_RST;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata <= MIM_RDATA_RST;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_o = rdata;
    assign irq_o = irq_pulse;
    // lets the async controller end the stuck access; not a flag, fires even when disabled
    assign timeout_event_o = timeout_pulse;

endmodule // mim_irq_masking

/* dv/mim_irq_masking_asserts.sv */
// port-level checks for the masked interrupt flag block
// assumes one clock domain; bound into every instance of the block
`timescale 1ns/1ps
module mim_irq_masking_chk import mim_pkg::*; #(
    parameter bit WAIT_PIN_PRESENT = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [MIM_ADDR_W-1:0] reg_addr_i,
    input wire logic [MIM_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [MIM_DATA_W-1:0] reg_rdata_o,
    input wire logic external_wait_pin_i,
    input wire logic ext_access_active_i,
    input wire logic line_trap_event_i,
    input wire logic irq_o,
    input wire logic timeout_event_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire rd_raw = reg_rd_i && reg_addr_i == MIM_OFS_RAW_FLAGS;
    wire rd_set = reg_rd_i && reg_addr_i == MIM_OFS_ENABLE_SET;
    wire rd_clr = reg_rd_i && reg_addr_i == MIM_OFS_ENABLE_CLEAR;
    wire wr_set = reg_wr_i && reg_addr_i == MIM_OFS_ENABLE_SET;
    wire wr_clr = reg_wr_i && reg_addr_i == MIM_OFS_ENABLE_CLEAR;
    wire wr_msk = reg_wr_i && reg_addr_i == MIM_OFS_MASKED_FLAGS;

    irq_one_cycle_a: assert property (irq_o |=> !irq_o)
        else $error("irq_o held longer than one cycle");
    irq_has_cause_a: assert property (irq_o |-> timeout_event_o)
        else $error("irq_o without a timeout event");
    event_one_cycle_a: assert property (timeout_event_o |=> !timeout_event_o)
        else $error("timeout event longer than one cycle");
    event_cause_a: assert property (timeout_event_o |-> $past(ext_access_active_i) && $past(ext_access_active_i, 2))
        else $error("timeout event without an access in progress");
    reserved_zero_a: assert property (reg_rd_i && reg_addr_i == MIM_OFS_MASKED_FLAGS |=> reg_rdata_o[31:3] == '0)
        else $error("reserved masked flag bits read nonzero");
    trap_raw_a: assert property (WAIT_PIN_PRESENT && line_trap_event_i ##1 rd_raw |=> reg_rdata_o[MIM_BIT_LINE_TRAP])
        else $error("line trap event not seen in raw flags");
    trap_clear_a: assert property (wr_msk && reg_wdata_i[MIM_BIT_LINE_TRAP] && !line_trap_event_i ##1 rd_raw
        |=> !reg_rdata_o[MIM_BIT_LINE_TRAP])
        else $error("masked clear left raw line trap set");
    enable_set_a: assert property (WAIT_PIN_PRESENT && wr_set && reg_wdata_i[MIM_BIT_TIMEOUT] ##1 rd_clr
        |=> reg_rdata_o[MIM_BIT_TIMEOUT])
        else $error("enable set not mirrored in clear view");
    enable_clear_a: assert property (wr_clr && reg_wdata_i[MIM_BIT_LINE_TRAP] ##1 rd_set
        |=> !reg_rdata_o[MIM_BIT_LINE_TRAP])
        else $error("enable clear did not clear enable");
endmodule // mim_irq_masking_chk

bind mim_irq_masking mim_irq_masking_chk #(.WAIT_PIN_PRESENT(WAIT_PIN_PRESENT)) u_mim_irq_masking_chk (
    .core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .external_wait_pin_i, .ext_access_active_i, .line_trap_event_i, .irq_o, .timeout_event_o);

/* dv/mim_cpu_intc.sv */
// stand-in for the cpu interrupt controller: counts interrupt pulses
// assumes irq_i is a one-cycle pulse on the core clock
`timescale 1ns/1ps
module mim_cpu_intc (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic irq_i,
    output int irq_cnt_o
);
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) irq_cnt_o <= 0;
        else if (irq_i) irq_cnt_o <= irq_cnt_o + 1;
    end
endmodule // mim_cpu_intc

/* dv/mim_irq_masking_test.sv */
// self-checking bench for the masked interrupt flag block
// assumes one 40 MHz clock; a second instance stands for the variant without the wait pin
`timescale 1ns/1ps
module mim_irq_masking_test;
    import mim_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [MIM_ADDR_W-1:0] reg_addr_i = '0;
    logic [MIM_DATA_W-1:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, external_wait_pin_i = 1'b0;
    logic ext_access_active_i = 1'b0, line_trap_event_i = 1'b0;
    logic [MIM_DATA_W-1:0] reg_rdata_o, rdata_np;
    logic irq_o, timeout_event_o;
    int irq_cnt, error_cnt = 0, tests_run = 0;

    mim_irq_masking u_mim_irq_masking (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .external_wait_pin_i, .ext_access_active_i, .line_trap_event_i, .irq_o, .timeout_event_o);
    mim_irq_masking #(.WAIT_PIN_PRESENT(1'b0)) u_mim_irq_masking_nopin (.core_clk_i, .rst_n_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(rdata_np), .external_wait_pin_i, .ext_access_active_i,
        .line_trap_event_i, .irq_o(), .timeout_event_o());
    mim_cpu_intc u_mim_cpu_intc (.core_clk_i, .rst_n_i, .irq_i(irq_o), .irq_cnt_o(irq_cnt));

    initial begin
        forever #(MIM_CLK_PERIOD_NS / 2.0) core_clk_i = ~core_clk_i;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // leaves the write strobe up so writes can follow back to back
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_wr_i <= 1'b1;
        reg_rd_i <= 1'b0;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] exp, string nm);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(nm, exp, reg_rdata_o);
        chk("no pin variant", '0, rdata_np);
        @(posedge core_clk_i);
    endtask

    task automatic trap_pulse();
        reg_wr_i <= 1'b0;
        line_trap_event_i <= 1'b1;
        @(posedge core_clk_i);
        line_trap_event_i <= 1'b0;
    endtask

    task automatic wait_evt(logic irq_exp);
        reg_wr_i <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(negedge core_clk_i);
            if (timeout_event_o === 1'b1) begin
                // 4 sync edges, 1 to enter counting, limit 2 plus one counts
                chk("timeout latency", 32'h0000_0008, i);
                chk("irq_o", irq_exp, irq_o);
                @(posedge core_clk_i);
                return;
            end
        end
        chk("timeout wait", 1, 0);
        final_report();
    endtask

    task automatic t_reset();
        rd(MIM_OFS_MASKED_FLAGS, '0, "masked reset");
        rd(MIM_OFS_ENABLE_SET, '0, "enable reset");
        rd(8'h20, '0, "unmapped");
    endtask

    task automatic t_trap();
        trap_pulse();
        rd(MIM_OFS_RAW_FLAGS, 32'h0000_0002, "raw trap");
        rd(MIM_OFS_MASKED_FLAGS, '0, "masked trap off");
        wr(MIM_OFS_ENABLE_SET, 32'h0000_0002);
        rd(MIM_OFS_ENABLE_CLEAR, 32'h0000_0002, "enable view");
        trap_pulse();
        rd(MIM_OFS_MASKED_FLAGS, 32'h0000_0002, "masked trap");
        wr(MIM_OFS_MASKED_FLAGS, '0);
        rd(MIM_OFS_RAW_FLAGS, 32'h0000_0002, "raw after zero");
        wr(MIM_OFS_MASKED_FLAGS, 32'h0000_0002);
        rd(MIM_OFS_RAW_FLAGS, '0, "raw trap clr");
        rd(MIM_OFS_MASKED_FLAGS, '0, "masked trap clr");
        wr(MIM_OFS_ENABLE_CLEAR, 32'h0000_0002);
        rd(MIM_OFS_ENABLE_SET, '0, "enable cleared");
    endtask

    task automatic t_to();
        wr(MIM_OFS_WAIT_CFG, 32'h0000_0002);
        external_wait_pin_i <= 1'b1;
        ext_access_active_i <= 1'b1;
        wait_evt(1'b0);
        external_wait_pin_i <= 1'b0;
        ext_access_active_i <= 1'b0;
        rd(MIM_OFS_RAW_FLAGS, 32'h0000_0005, "raw to off");
        rd(MIM_OFS_MASKED_FLAGS, '0, "masked to off");
        wr(MIM_OFS_RAW_FLAGS, 32'h0000_0005);
        wr(MIM_OFS_ENABLE_SET, 32'h0000_0005);
        rd(MIM_OFS_ENABLE_CLEAR, 32'h0000_0005, "enables on");
        external_wait_pin_i <= 1'b1;
        ext_access_active_i <= 1'b1;
        wait_evt(1'b1);
        external_wait_pin_i <= 1'b0;
        ext_access_active_i <= 1'b0;
        rd(MIM_OFS_MASKED_FLAGS, 32'h0000_0005, "masked to on");
        wr(MIM_OFS_MASKED_FLAGS, 32'h0000_0001);
        rd(MIM_OFS_RAW_FLAGS, 32'h0000_0004, "raw to clr");
        rd(MIM_OFS_MASKED_FLAGS, 32'h0000_0004, "masked to clr");
        wr(MIM_OFS_MASKED_FLAGS, 32'h0000_0004);
        rd(MIM_OFS_RAW_FLAGS, '0, "raw rise clr");
        rd(MIM_OFS_MASKED_FLAGS, '0, "masked rise clr");
        chk("irq count", 1, irq_cnt);
    endtask

    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        t_reset();
        t_trap();
        t_to();
        final_report();
    end
endmodule // mim_irq_masking_test
